// ===== adc_ctl_map.vh
// constants for the dual converter readout and power control block
// assumes a 50 MHz mclk; all counts are in mclk or conversion-clock edges
`ifndef ADC_CTL_MAP_VH
`define ADC_CTL_MAP_VH

// system clock rate and software reset recovery time
`define MCLK_MHZ 50
`define SRST_NS 20
`define SRST_CYC (((`SRST_NS * `MCLK_MHZ) + 999) / 1000)

// conversion clock counts
`define HALF_CYCLE_CLKS 20
`define FULL_CYCLE_CLKS 40
`define BUSY_HALF_CLKS 16
`define BUSY_FULL_CLKS 34
`define WAKE_HALF_CLKS 7
`define WAKE_FULL_CLKS 14
`define CH_LATCH_CLK 2
`define FRAME_BITS 20

// control word layout: command address on top, payload below
`define CMD_ADDR_MSB 15
`define CMD_ADDR_LSB 12
`define CMD_WR_CFG 4'h1
`define CMD_SW_RESET 4'h4

// configuration payload fields
`define CFG_PD_MSB 1
`define CFG_PD_LSB 0
`define CFG_CID_BIT 2
`define CFG_CE_BIT 3
`define CFG_FC_BIT 4
`define CFG_FE_BIT 5
`define CFG_CH_MSB 7
`define CFG_CH_LSB 6
`define CFG_S1_BIT 8
`define CFG_SEQ_BIT 9
`define CFG_WIDTH 10

// power-down field codes
`define PD_NORMAL 2'h0
`define PD_FULL 2'h1
`define PD_SLEEP 2'h2
`define PD_AUTO 2'h3

// reset values
`define CFG_RESET 10'h000
`define FRESH_RESET 2'h1

`endif

// ===== adc_ctl.v
// dual converter readout, freshness counter, power modes and soft reset
// assumes all pins synchronous to mclk; conv_clk is sampled as a level
`timescale 1ns/1ps
`include "adc_ctl_map.vh"

module cmd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire push;
  wire pop;

  // one extra pointer bit tells full from empty
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != DEPTH[AW:0];
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset; only pointers need a defined value
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointer update
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // cmd_fifo

module adc_ctl (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // host control pins
  input wire conv_clk,
  input wire conversion_start,
  input wire read_strobe,
  input wire cs_n,
  input wire serial_in,
  input wire channel_select_mode_pin,
  input wire output_lane_mode_pin,
  // converter core results and sequencer
  input wire [15:0] core_result_a,
  input wire [15:0] core_result_b,
  input wire sequence_last,
  // serial data outputs
  output wire serial_out_a,
  output wire serial_out_b,
  // status
  output wire busy,
  output wire track_hold,
  output wire bias_on,
  output wire full_power_down,
  output wire result_queue_en,
  output wire cmd_ready,
  output wire [1:0] mux_channel
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAKE = 2'd1;
  localparam ST_BUSY = 2'd2;
  localparam SRST_HOLD = `SRST_CYC;
  // builds one output frame: indicator or MSB first
  function [19:0] build_frame;
    input channel_info_disable;
    input ch_bit;
    input [15:0] data;
    input ce;
    input [1:0] cnt;
    reg [1:0] tail;
    begin
      tail = ce ? cnt : 2'h0;
      if (channel_info_disable) begin
        build_frame = {data, tail, 2'h0};
      end else begin
        build_frame = {ch_bit, 1'b0, data, tail};
      end
    end
  endfunction

  // pin history for edge detection
  reg clk_q_reg;
  reg start_q_reg;
  reg rd_q_reg;
  wire clk_rise;
  wire clk_fall;
  wire start_rise;
  wire rd_fall;

  // configuration and power state
  reg [`CFG_WIDTH-1:0] cfg_reg;
  reg asleep_reg;
  reg pd_full_reg;
  wire [1:0] pd_field;
  wire full_clock;

  // conversion sequencer
  reg [1:0] state_reg;
  reg [5:0] ccnt_reg;
  reg [1:0] next_ch_reg;
  reg [1:0] cur_ch_reg;

  // output register and freshness counter
  reg [15:0] res_a_reg;
  reg [15:0] res_b_reg;
  reg [1:0] res_ch_reg;
  reg [1:0] res_cnt_reg;
  reg [1:0] fresh_reg;
  reg ch_valid_reg;

  // serial frame
  reg frame_reg;
  reg [4:0] bit_cnt_reg;
  reg [19:0] sh_a_reg;
  reg [19:0] sh_b_reg;
  reg [15:0] sin_reg;

  // soft reset and command path
  reg soft_rst_reg;
  reg [1:0] hold_reg;
  wire rst_all;
  wire sif_hold;
  wire mode_one;
  wire [5:0] busy_len;
  wire [5:0] wake_len;
  wire frame_done;
  wire [3:0] word_addr;
  wire cmd_push;
  wire cmd_pop;
  wire cmd_valid;
  wire [15:0] cmd_word;
  wire [15:0] word_in;

  assign rst_all = !rst_n || soft_rst_reg;
  assign sif_hold = hold_reg != 2'h0;
  assign pd_field = cfg_reg[`CFG_PD_MSB:`CFG_PD_LSB];
  assign full_clock = cfg_reg[`CFG_FC_BIT];
  assign clk_rise = conv_clk && !clk_q_reg;
  assign clk_fall = !conv_clk && clk_q_reg;
  assign start_rise = conversion_start && !start_q_reg;
  assign rd_fall = !read_strobe && rd_q_reg && !sif_hold;
  assign mode_one = !channel_select_mode_pin && !output_lane_mode_pin;

  // conversion lengths depend on clock mode
  assign busy_len = full_clock ? 6'd`BUSY_FULL_CLKS : 6'd`BUSY_HALF_CLKS;
  assign wake_len = full_clock ? 6'd`WAKE_FULL_CLKS : 6'd`WAKE_HALF_CLKS;

  // queue is only usable in half-clock, non-manual modes
  assign result_queue_en = cfg_reg[`CFG_FE_BIT] && !full_clock && !mode_one;

  // status outputs straight from state flops; serial outputs gated by cs_n and the mode pins
  assign busy = state_reg == ST_BUSY;
  assign track_hold = state_reg == ST_BUSY;
  assign bias_on = !asleep_reg && !pd_full_reg;
  assign full_power_down = pd_full_reg;
  assign mux_channel = cur_ch_reg;
  assign serial_out_a = !cs_n && mode_one && sh_a_reg[19];
  assign serial_out_b = !cs_n && mode_one && sh_b_reg[19];

  // the last bit of a frame also ends the control word access
  assign word_in = {sin_reg[14:0], serial_in};
  assign frame_done = frame_reg && (bit_cnt_reg == 5'd`FRAME_BITS - 5'd1)
                      && (full_clock ? clk_fall : clk_rise);
  assign word_addr = sin_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  assign cmd_push = frame_done && (word_addr != `CMD_SW_RESET);

  // config commands wait until no conversion runs
  assign cmd_pop = cmd_valid && (state_reg == ST_IDLE);

  cmd_fifo #(
    .WIDTH(16),
    .DEPTH(16),
    .AW(4)
  ) u_cmd_fifo (
    .mclk(mclk),
    .rst_n(!rst_all),
    .in_valid(cmd_push),
    .in_ready(cmd_ready),
    .in_data(sin_reg),
    .out_valid(cmd_valid),
    .out_ready(cmd_pop),
    .out_data(cmd_word)
  );

  // pin history; kept through soft reset so no false edge appears
  always @(posedge mclk) begin
    if (!rst_n) begin
      clk_q_reg <= 1'b0;
      start_q_reg <= 1'b0;
      rd_q_reg <= 1'b0;
    end else begin
      clk_q_reg <= conv_clk;
      start_q_reg <= conversion_start;
      rd_q_reg <= read_strobe;
    end
  end

  // soft reset pulse and interface hold-off after it
  always @(posedge mclk) begin
    if (!rst_n) begin
      soft_rst_reg <= 1'b0;
      hold_reg <= 2'h0;
    end else if (soft_rst_reg) begin
      soft_rst_reg <= 1'b0;
      hold_reg <= SRST_HOLD[1:0];
    end else begin
      soft_rst_reg <= frame_done && (word_addr == `CMD_SW_RESET);
      if (sif_hold) begin
        hold_reg <= hold_reg - 2'h1;
      end
    end
  end

  // configuration register and power modes
  always @(posedge mclk) begin
    if (rst_all) begin
      cfg_reg <= `CFG_RESET;
      asleep_reg <= 1'b0;
      pd_full_reg <= 1'b0;
    end else if (cmd_pop && cmd_word[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `CMD_WR_CFG) begin
      // power modes change only flags, the stored field stays as written
      cfg_reg <= cmd_word[`CFG_WIDTH-1:0];
      case (cmd_word[`CFG_PD_MSB:`CFG_PD_LSB])
        `PD_FULL: begin
          pd_full_reg <= 1'b1;
          asleep_reg <= 1'b0;
        end
        `PD_SLEEP: begin
          pd_full_reg <= 1'b0;
          asleep_reg <= 1'b1;
        end
        `PD_AUTO: begin
          pd_full_reg <= 1'b0;
          asleep_reg <= 1'b0;
        end
        default: begin
          pd_full_reg <= 1'b0;
          asleep_reg <= 1'b0;
        end
      endcase
    end else if (state_reg == ST_IDLE && start_rise && pd_field == `PD_AUTO) begin
      asleep_reg <= 1'b0;
    end else if (state_reg == ST_BUSY && clk_rise && ccnt_reg == busy_len - 6'd1
                 && pd_field == `PD_AUTO) begin
      // with one start per sequence, sleep waits for the last step
      if (!(cfg_reg[`CFG_SEQ_BIT] && cfg_reg[`CFG_S1_BIT] && !sequence_last)) begin
        asleep_reg <= 1'b1;
      end
    end
  end

  // conversion sequencer: idle, wake settling, busy
  always @(posedge mclk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
      ccnt_reg <= 6'd0;
      next_ch_reg <= 2'h0;
      cur_ch_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          ccnt_reg <= 6'd0;
          // sleep and full power-down ignore start pulses
          if (start_rise && !pd_full_reg) begin
            if (pd_field == `PD_AUTO && asleep_reg) begin
              state_reg <= ST_WAKE;
            end else if (!asleep_reg) begin
              state_reg <= ST_BUSY;
              cur_ch_reg <= next_ch_reg;
            end
          end
        end
        ST_WAKE: begin
          // input keeps sampling while bias settles
          if (clk_rise) begin
            if (ccnt_reg == wake_len - 6'd1) begin
              ccnt_reg <= 6'd0;
              state_reg <= ST_BUSY;
              cur_ch_reg <= next_ch_reg;
            end else begin
              ccnt_reg <= ccnt_reg + 6'd1;
            end
          end
        end
        ST_BUSY: begin
          if (clk_fall && ccnt_reg == 6'd`CH_LATCH_CLK && !channel_select_mode_pin) begin
            next_ch_reg <= cfg_reg[`CFG_CH_MSB:`CFG_CH_LSB];
          end
          if (clk_rise) begin
            if (ccnt_reg == busy_len - 6'd1) begin
              state_reg <= ST_IDLE;
            end
            ccnt_reg <= ccnt_reg + 6'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // output register and freshness counter
  always @(posedge mclk) begin
    if (rst_all) begin
      res_a_reg <= 16'h0000;
      res_b_reg <= 16'h0000;
      res_ch_reg <= 2'h0;
      res_cnt_reg <= 2'h0;
      fresh_reg <= `FRESH_RESET;
      ch_valid_reg <= 1'b0;
    end else if (state_reg == ST_BUSY && clk_rise && ccnt_reg == busy_len - 6'd1) begin
      // codes pass through untouched as two's complement
      res_a_reg <= core_result_a;
      res_b_reg <= core_result_b;
      res_ch_reg <= cur_ch_reg;
      res_cnt_reg <= fresh_reg;
      fresh_reg <= fresh_reg + 2'h1;
      ch_valid_reg <= 1'b1;
    end else if (rd_fall && !cs_n && full_clock) begin
      ch_valid_reg <= 1'b0;
    end
  end

  // serial frame: load on strobe fall, shift on the mode's clock edge
  always @(posedge mclk) begin
    if (rst_all) begin
      frame_reg <= 1'b0;
      bit_cnt_reg <= 5'd0;
      sh_a_reg <= 20'h00000;
      sh_b_reg <= 20'h00000;
      sin_reg <= 16'h0000;
    end else if (rd_fall && !cs_n) begin
      // repeated reads reload the same stored result
      frame_reg <= 1'b1;
      bit_cnt_reg <= 5'd0;
      sin_reg <= 16'h0000;
      sh_a_reg <= build_frame(cfg_reg[`CFG_CID_BIT], res_ch_reg[0] && ch_valid_reg,
                              res_a_reg, cfg_reg[`CFG_CE_BIT], res_cnt_reg);
      sh_b_reg <= build_frame(cfg_reg[`CFG_CID_BIT], res_ch_reg[1] && ch_valid_reg,
                              res_b_reg, cfg_reg[`CFG_CE_BIT], res_cnt_reg);
    end else if (frame_reg && (full_clock ? clk_fall : clk_rise)) begin
      sh_a_reg <= {sh_a_reg[18:0], 1'b0};
      sh_b_reg <= {sh_b_reg[18:0], 1'b0};
      if (bit_cnt_reg < 5'd16) begin
        sin_reg <= word_in;
      end
      if (frame_done) begin
        frame_reg <= 1'b0;
      end
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end
  end
endmodule // adc_ctl

// ===== adc_ctl_props.sv
// port checker for the converter control block
// assumes one clock, mclk, and a synchronous active-low rst_n
`timescale 1ns/1ps
module adc_ctl_props (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // pins
  input wire conv_clk,
  input wire cs_n,
  input wire channel_select_mode_pin,
  input wire output_lane_mode_pin,
  // outputs
  input wire serial_out_a,
  input wire serial_out_b,
  input wire busy,
  input wire track_hold,
  input wire bias_on,
  input wire full_power_down,
  input wire result_queue_en,
  input wire cmd_ready
);
  // mode I is the only lane mode that puts data out
  wire mode_one = !channel_select_mode_pin && !output_lane_mode_pin;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_hold_tracks_busy: assert property (track_hold == busy)
    else $error("hold differs from busy");
  chk_cs_gates_out: assert property (cs_n |-> !serial_out_a && !serial_out_b)
    else $error("output active while deselected");
  chk_mode_gates_out: assert property (!mode_one |-> !serial_out_a && !serial_out_b)
    else $error("output active outside mode one");
  chk_queue_off_mode: assert property (mode_one |-> !result_queue_en)
    else $error("queue enabled in mode one");
  chk_pd_no_bias: assert property (full_power_down |-> !bias_on)
    else $error("bias on in power-down");
  chk_pd_no_start: assert property ($rose(busy) |-> !$past(full_power_down))
    else $error("conversion began in power-down");
  chk_reset_idle: assert property ($rose(rst_n) |->
    !busy && bias_on && !full_power_down && cmd_ready)
    else $error("state after reset wrong");
  chk_busy_end_clock: assert property ($fell(busy) |-> $past(conv_clk))
    else $error("busy ended without a clock rise");
  // main scenarios
  cov_conv_done: cover property ($fell(busy));
  cov_power_down: cover property ($rose(full_power_down));
  cov_data_out: cover property ($rose(serial_out_a));
endmodule // adc_ctl_props

bind adc_ctl adc_ctl_props u_props (.mclk, .rst_n, .conv_clk, .cs_n, .channel_select_mode_pin,
  .output_lane_mode_pin, .serial_out_a, .serial_out_b, .busy, .track_hold, .bias_on,
  .full_power_down, .result_queue_en, .cmd_ready);

// ===== host_clk.sv
// host model: supplies the free-running conversion clock
// assumes mclk is the system clock; conv_clk moves on its falling edge
`timescale 1ns/1ps
module host_clk #(
  parameter HALF = 4
) (
  // system clock
  input wire mclk,
  // conversion clock to the device
  output reg conv_clk
);
  integer cnt = 0;
  // toggle away from the sampling edge so the device never races it
  initial conv_clk = 1'b0;
  always @(negedge mclk) begin
    cnt = (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == 0) conv_clk <= ~conv_clk;
  end
endmodule // host_clk

// ===== testbench.sv
// self-checking bench for the converter control block
// assumes the host model clocks conversions; pins move at mclk rises
`timescale 1ns/1ps
`include "adc_ctl_map.vh"
module testbench;
  // pins and observers
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg conversion_start = 1'b0;
  reg read_strobe = 1'b0;
  reg cs_n = 1'b0;
  reg serial_in = 1'b0;
  reg mode0 = 1'b0;
  reg [15:0] res_a = 16'h0000;
  reg [15:0] res_b = 16'h0000;
  reg cc_d = 1'b0;
  reg rise_seen = 1'b0;
  reg fall_seen = 1'b0;
  reg full_mode = 1'b0;
  reg seq_last = 1'b0;
  reg [19:0] fa;
  reg [19:0] fb;
  wire conv_clk, sa, sb, busy, hold, bias_on, full_pd, queue_en, cmd_ready;
  wire [1:0] mux_channel;
  wire [6:0] flags = {busy, bias_on, full_pd, queue_en, cmd_ready, mux_channel};
  // frames shift on rises in half-clock mode and on falls in full-clock mode
  wire shift_seen = full_mode ? fall_seen : rise_seen;
  integer miscompares = 0;
  integer comparisons = 0;
  integer wake_n, busy_n, n;
  host_clk u_host (.mclk(mclk), .conv_clk(conv_clk));
  adc_ctl u_dut (.mclk(mclk), .rst_n(rst_n), .conv_clk(conv_clk),
    .conversion_start(conversion_start), .read_strobe(read_strobe), .cs_n(cs_n),
    .serial_in(serial_in), .channel_select_mode_pin(mode0), .output_lane_mode_pin(1'b0),
    .core_result_a(res_a), .core_result_b(res_b), .sequence_last(seq_last),
    .serial_out_a(sa), .serial_out_b(sb), .busy(busy), .track_hold(hold),
    .bias_on(bias_on), .full_power_down(full_pd), .result_queue_en(queue_en),
    .cmd_ready(cmd_ready), .mux_channel(mux_channel));
  initial forever #10 mclk = ~mclk;
  // mirror of the device's clock edge detection, readable just after each edge
  always @(posedge mclk) begin
    cc_d <= conv_clk;
    rise_seen <= conv_clk & ~cc_d;
    fall_seen <= ~conv_clk & cc_d;
  end
  task step;
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task check(input string what, input [19:0] exp, input [19:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // always moves past one edge first, so the edge just handled is never seen twice
  task wait_shift;
    begin
      n = 0;
      step;
      while (!shift_seen && n < 100) begin
        step;
        n = n + 1;
      end
    end
  endtask
  // one read access: word in, both 20-bit frames out, msb first
  task frame(input [15:0] w);
    integer i;
    begin
      @(posedge mclk) read_strobe <= 1'b1;
      serial_in <= w[15];
      @(posedge mclk) read_strobe <= 1'b0;
      step;
      // first bit stands from the load edge until the first shift edge
      fa[19] = sa;
      fb[19] = sb;
      for (i = 1; i < 21; i = i + 1) begin
        wait_shift;
        serial_in <= (i < 16) ? w[15-i] : 1'b0;
        if (i < 20) begin
          fa[19-i] = sa;
          fb[19-i] = sb;
        end
      end
    end
  endtask
  // frame has fully ended; slack lets the queued command apply while idle
  task cfg(input [9:0] c);
    begin
      frame({`CMD_WR_CFG, 2'b00, c});
      repeat (12) step;
      full_mode = c[4];
    end
  endtask
  // start pulse, then count clock rises before and during busy
  task convert;
    begin
      @(posedge mclk) conversion_start <= 1'b1;
      @(posedge mclk) conversion_start <= 1'b0;
      #1;
      wake_n = 0;
      busy_n = 0;
      // count a rise after its edge, so the rise that ends a phase counts too
      while (busy !== 1'b1 && wake_n < 30) begin
        step;
        if (rise_seen) wake_n = wake_n + 1;
      end
      if (busy === 1'b1) check("hold in conversion", 1'b1, hold);
      while (busy === 1'b1 && busy_n < 60) begin
        step;
        if (rise_seen) busy_n = busy_n + 1;
      end
    end
  endtask
  task t_format;
    reg [15:0] v;
    integer j;
    begin
      cfg(10'h00C);
      for (j = 0; j < 4; j = j + 1) begin
        v = (j == 0) ? 16'h7FFF : (j == 1) ? 16'h0000 : (j == 2) ? 16'hFFFF : 16'h8000;
        res_a <= v;
        res_b <= ~v;
        convert;
        check("busy clocks", `BUSY_HALF_CLKS, busy_n);
        frame(16'h0000);
        check("frame a", {v, j[1:0] + 2'h1, 2'h0}, fa);
        check("frame b", {~v, j[1:0] + 2'h1, 2'h0}, fb);
      end
      frame(16'h0000);
      check("repeat read", {16'h8000, 2'h0, 2'h0}, fa);
    end
  endtask
  task t_chan;
    begin
      cfg(10'h040);
      res_a <= 16'h1234;
      convert;
      convert;
      check("channel", 2'h1, mux_channel);
      frame(16'h0000);
      check("info frame", {1'b0, 16'h1234, 2'h0}, fa[18:0]);
      cs_n <= 1'b1;
      step;
      check("deselected", 2'h0, {sa, sb});
      cs_n <= 1'b0;
    end
  endtask
  task t_queue;
    begin
      cfg(10'h020);
      check("queue mode one", 1'b0, queue_en);
      mode0 <= 1'b1;
      step;
      check("queue mode three", 1'b1, queue_en);
      mode0 <= 1'b0;
      cfg(10'h030);
      check("queue full clock", 1'b0, queue_en);
      convert;
      check("full busy clocks", `BUSY_FULL_CLKS, busy_n);
      cfg(10'h000);
    end
  endtask
  task t_power;
    begin
      cfg(10'h001);
      check("power down", 2'h1, {bias_on, full_pd});
      convert;
      check("start refused", 0, busy_n);
      cfg(10'h000);
      check("power up", 2'h2, {bias_on, full_pd});
      cfg(10'h002);
      check("sleep", 2'h0, {bias_on, full_pd});
      cfg(10'h003);
      convert;
      check("auto sleep", 1'b0, bias_on);
      convert;
      check("wake clocks", `WAKE_HALF_CLKS, wake_n);
      cfg(10'h303);
      convert;
      check("sequence awake", 1'b1, bias_on);
      seq_last <= 1'b1;
      convert;
      check("sequence done", 1'b0, bias_on);
      seq_last <= 1'b0;
      cfg(10'h000);
    end
  endtask
  task t_reset;
    begin
      cfg(10'h009);
      frame({`CMD_SW_RESET, 12'h000});
      repeat (4) step;
      check("after reset", 7'h24, flags & 7'h7C);
      convert;
      frame(16'h0000);
      check("frame after reset", {16'h1234, 2'h0}, fa[17:0]);
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    step;
    check("reset state", 7'h24, flags);
    t_format;
    t_chan;
    t_queue;
    t_power;
    t_reset;
    finish_test;
  end
  // cuts a hang short well past the expected run length
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule // testbench
